// ### hw/startup_supervisor_defs.vh
// constants for the motor startup supervisor: register map, setting ranges,
// reset values, hysteresis factors and timing.
// assumes a 40 MHz clock and currents given in percent of the input rated current.
`ifndef STARTUP_SUPERVISOR_DEFS_VH
`define STARTUP_SUPERVISOR_DEFS_VH

// register byte addresses
`define REG_CTRL          8'h00
`define REG_RATIO         8'h04
`define REG_START_THR     8'h08
`define REG_IDLE_THR      8'h0C
`define REG_START_TIME    8'h10
`define REG_RESTART_TIME  8'h14
`define REG_STATUS        8'h18
`define REG_IMAX          8'h1C
`define REG_TIMERS        8'h20
`define REG_START_COUNT   8'h24

// field positions
`define CTRL_OPER_BIT     0
`define ST_STARTING_BIT   0
`define ST_RUNNING_BIT    1
`define ST_PROLONGED_BIT  2
`define ST_BLOCKED_BIT    3
`define ST_HIGH_BIT       4
`define ST_STATE_LSB      8

// setting ranges and resets
`define RATIO_MIN         16'h0014
`define RATIO_MAX         16'h0096
`define RATIO_RST         16'h0064
`define START_THR_MIN     16'h0032
`define START_THR_MAX     16'h03E8
`define START_THR_RST     16'h00C8
`define IDLE_THR_MIN      16'h0005
`define IDLE_THR_MAX      16'h0032
`define IDLE_THR_RST      16'h000A
`define START_TIME_MIN    16'h0001
`define START_TIME_MAX    16'h0064
`define START_TIME_RST    16'h0005
`define RESTART_TIME_MIN  16'h000A
`define RESTART_TIME_MAX  16'h1388
`define RESTART_TIME_RST  16'h0014

// hysteresis, in percent of the pick-up level
`define PCT_FULL          32'h0000_0064
`define PCT_START_RESET   32'h0000_005F
`define PCT_IDLE_RESET    32'h0000_0046

// timing
`define CLK_HZ            40000000
`define TIMER_STEP_S      1
`define TICK_CYCLES       (`CLK_HZ * `TIMER_STEP_S)

`endif

// ### hw/hyst_compare.v
// hysteresis comparator of a current against a threshold scaled by the ratio.
// assumes value in percent of input rated current, threshold in percent of motor rating.
`timescale 1ns/1ps
`default_nettype none
`include "startup_supervisor_defs.vh"
module hyst_compare #(
    parameter [31:0] RESET_PCT = `PCT_START_RESET
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // operands
    input  wire        enable_i,
    input  wire [15:0] value_i,
    input  wire [15:0] thr_i,
    input  wire [15:0] ratio_i,
    // result
    output reg         above_o
);
    wire [31:0] lhs;
    wire [31:0] base;
    wire [31:0] on_lim;
    wire [31:0] off_lim;

    // value*100*100 against thr*ratio*pct keeps every term integer
    assign lhs     = {16'h0000, value_i} * `PCT_FULL * `PCT_FULL;
    assign base    = {16'h0000, thr_i} * {16'h0000, ratio_i};
    assign on_lim  = base * `PCT_FULL;
    assign off_lim = base * RESET_PCT;

    always @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            above_o <= 1'b0;
        end else if (above_o) begin
            above_o <= (lhs >= off_lim);
        end else begin
            above_o <= (lhs > on_lim);
        end
    end
endmodule
`default_nettype wire

// ### hw/startup_supervisor.v
// motor startup supervisor with a classic wishbone register slave.
// assumes phase magnitudes come from logic on clk_i, held between valid strobes.
`timescale 1ns/1ps
`default_nettype none
`include "startup_supervisor_defs.vh"
module startup_supervisor #(
    parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // phase-current magnitudes, percent of input rated current
    input  wire        meas_valid_i,
    input  wire [15:0] mag_a_i,
    input  wire [15:0] mag_b_i,
    input  wire [15:0] mag_c_i,
    // status outputs
    output reg         starting_flag_o,
    output reg         running_flag_o,
    output reg         prolonged_start_flag_o,
    output reg         restart_blocked_flag_o
);
    localparam [1:0] ST_IDLE     = 2'b00;
    localparam [1:0] ST_STARTING = 2'b01;
    localparam [1:0] ST_RUN      = 2'b10;

    // largest of three magnitudes
    function [15:0] max3;
        input [15:0] a;
        input [15:0] b;
        input [15:0] c;
        reg   [15:0] m;
        begin
            m = (a > b) ? a : b;
            max3 = (m > c) ? m : c;
        end
    endfunction

    // byte-lane merge of a 16-bit field
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // limit a setting to its range
    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    reg         oper_q;
    reg  [15:0] ratio_q;
    reg  [15:0] start_thr_q;
    reg  [15:0] idle_thr_q;
    reg  [15:0] start_time_q;
    reg  [15:0] restart_time_q;
    reg  [15:0] imax_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [31:0] tick_cnt_q;
    reg         tick_q;
    reg  [15:0] start_left_q;
    reg  [15:0] start_left_d;
    reg  [15:0] inhibit_left_q;
    reg  [15:0] inhibit_left_d;
    reg         idle_above_prev_q;
    reg  [15:0] start_count_q;
    reg         prolonged_d;
    reg         load_inhibit;
    reg         start_event;
    wire        idle_above;
    wire        high_above;
    wire        wb_req;
    wire        wb_wr;
    wire [15:0] wr_ratio;
    wire [15:0] wr_start_thr;
    wire [15:0] wr_idle_thr;
    wire [15:0] wr_start_time;
    wire [15:0] wr_restart_time;

    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign wb_wr  = wb_req & we_i;

    assign wr_ratio        = clamp16(merge16(ratio_q, dat_i, sel_i),
                                     `RATIO_MIN, `RATIO_MAX);
    assign wr_start_thr    = clamp16(merge16(start_thr_q, dat_i, sel_i),
                                     `START_THR_MIN, `START_THR_MAX);
    assign wr_idle_thr     = clamp16(merge16(idle_thr_q, dat_i, sel_i),
                                     `IDLE_THR_MIN, `IDLE_THR_MAX);
    assign wr_start_time   = clamp16(merge16(start_time_q, dat_i, sel_i),
                                     `START_TIME_MIN, `START_TIME_MAX);
    assign wr_restart_time = clamp16(merge16(restart_time_q, dat_i, sel_i),
                                     `RESTART_TIME_MIN, `RESTART_TIME_MAX);

    // settings registers, clamped to range on write
    always @(posedge clk_i) begin
        if (rst_i) begin
            oper_q         <= 1'b0;
            ratio_q        <= `RATIO_RST;
            start_thr_q    <= `START_THR_RST;
            idle_thr_q     <= `IDLE_THR_RST;
            start_time_q   <= `START_TIME_RST;
            restart_time_q <= `RESTART_TIME_RST;
        end else if (wb_wr) begin
            case (adr_i)
                `REG_CTRL: begin
                    if (sel_i[0]) begin
                        oper_q <= dat_i[`CTRL_OPER_BIT];
                    end
                end
                `REG_RATIO:        ratio_q        <= wr_ratio;
                `REG_START_THR:    start_thr_q    <= wr_start_thr;
                `REG_IDLE_THR:     idle_thr_q     <= wr_idle_thr;
                `REG_START_TIME:   start_time_q   <= wr_start_time;
                `REG_RESTART_TIME: restart_time_q <= wr_restart_time;
                default: begin
                end
            endcase
        end
    end

    // read mux and single-cycle acknowledge
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            dat_o <= 32'h0000_0000;
            if (wb_req && !we_i) begin
                case (adr_i)
                    `REG_CTRL:         dat_o <= {31'h0000_0000, oper_q};
                    `REG_RATIO:        dat_o <= {16'h0000, ratio_q};
                    `REG_START_THR:    dat_o <= {16'h0000, start_thr_q};
                    `REG_IDLE_THR:     dat_o <= {16'h0000, idle_thr_q};
                    `REG_START_TIME:   dat_o <= {16'h0000, start_time_q};
                    `REG_RESTART_TIME: dat_o <= {16'h0000, restart_time_q};
                    `REG_STATUS: begin
                        dat_o[`ST_STARTING_BIT]  <= starting_flag_o;
                        dat_o[`ST_RUNNING_BIT]   <= running_flag_o;
                        dat_o[`ST_PROLONGED_BIT] <= prolonged_start_flag_o;
                        dat_o[`ST_BLOCKED_BIT]   <= restart_blocked_flag_o;
                        dat_o[`ST_HIGH_BIT]      <= high_above;
                        dat_o[`ST_STATE_LSB+1:`ST_STATE_LSB] <= state_q;
                    end
                    `REG_IMAX:         dat_o <= {16'h0000, imax_q};
                    `REG_TIMERS:       dat_o <= {inhibit_left_q, start_left_q};
                    `REG_START_COUNT:  dat_o <= {16'h0000, start_count_q};
                    default:           dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // largest phase magnitude, captured on each valid measurement
    always @(posedge clk_i) begin
        if (rst_i) begin
            imax_q <= 16'h0000;
        end else if (meas_valid_i) begin
            imax_q <= max3(mag_a_i, mag_b_i, mag_c_i);
        end
    end

    // idle and startup current comparators
    hyst_compare #(
        .RESET_PCT (`PCT_IDLE_RESET)
    ) u_idle_cmp (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (oper_q),
        .value_i  (imax_q),
        .thr_i    (idle_thr_q),
        .ratio_i  (ratio_q),
        .above_o  (idle_above)
    );

    hyst_compare #(
        .RESET_PCT (`PCT_START_RESET)
    ) u_high_cmp (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (oper_q),
        .value_i  (imax_q),
        .thr_i    (start_thr_q),
        .ratio_i  (ratio_q),
        .above_o  (high_above)
    );

    // one-second tick
    always @(posedge clk_i) begin
        if (rst_i || !oper_q) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES - 32'h0000_0001) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // supervision state machine
    always @* begin
        state_d      = state_q;
        start_left_d = start_left_q;
        prolonged_d  = prolonged_start_flag_o;
        load_inhibit = 1'b0;
        start_event  = 1'b0;
        case (state_q)
            ST_IDLE: begin
                prolonged_d = 1'b0;
                if (idle_above && !idle_above_prev_q) begin
                    start_event  = 1'b1;
                    start_left_d = start_time_q;
                    state_d      = ST_STARTING;
                end
            end
            ST_STARTING: begin
                if (!idle_above) begin
                    load_inhibit = 1'b1;
                    start_left_d = 16'h0000;
                    state_d      = ST_IDLE;
                end else if (tick_q) begin
                    if (start_left_q <= 16'h0001) begin
                        start_left_d = 16'h0000;
                        load_inhibit = 1'b1;
                        prolonged_d  = high_above;
                        state_d      = ST_RUN;
                    end else begin
                        start_left_d = start_left_q - 16'h0001;
                    end
                end
            end
            ST_RUN: begin
                prolonged_d = prolonged_start_flag_o & high_above;
                if (!idle_above) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d      = ST_IDLE;
                start_left_d = 16'h0000;
                prolonged_d  = 1'b0;
            end
        endcase
    end

    // restart-inhibit countdown
    always @* begin
        inhibit_left_d = inhibit_left_q;
        if (load_inhibit) begin
            inhibit_left_d = restart_time_q;
        end else if (tick_q && inhibit_left_q != 16'h0000) begin
            inhibit_left_d = inhibit_left_q - 16'h0001;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || !oper_q) begin
            state_q                <= ST_IDLE;
            start_left_q           <= 16'h0000;
            inhibit_left_q         <= 16'h0000;
            idle_above_prev_q      <= 1'b0;
            starting_flag_o        <= 1'b0;
            running_flag_o         <= 1'b0;
            prolonged_start_flag_o <= 1'b0;
            restart_blocked_flag_o <= 1'b0;
        end else begin
            state_q                <= state_d;
            start_left_q           <= start_left_d;
            inhibit_left_q         <= inhibit_left_d;
            idle_above_prev_q      <= idle_above;
            starting_flag_o        <= (state_d == ST_STARTING);
            running_flag_o         <= idle_above;
            prolonged_start_flag_o <= prolonged_d;
            restart_blocked_flag_o <= (inhibit_left_d != 16'h0000);
        end
    end

    // number of recognised starts, wraps
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_count_q <= 16'h0000;
        end else if (oper_q && start_event) begin
            start_count_q <= start_count_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### testbench/startup_supervisor_asserts.sv
// checker for the startup supervisor: bus handshake and flag timing at the top ports.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module startup_supervisor_asserts #(
    parameter [31:0] TICK_CYCLES = 32'h0000_000A
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // measurement and flags
    input wire logic        meas_valid_i,
    input wire logic        starting_flag_o,
    input wire logic        running_flag_o,
    input wire logic        prolonged_start_flag_o,
    input wire logic        restart_blocked_flag_o
);
    logic oper_q;
    // operation setting as last written over the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oper_q <= 1'b0;
        end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00 && sel_i[0]) begin
            oper_q <= dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence start_end_s;
        $fell(starting_flag_o) && oper_q;
    endsequence
    ack_answer_a: assert property (bus_req_s |=> ack_o)
        else $error("bus request not acknowledged next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");
    oper_off_a: assert property (!oper_q [*3] |-> !(starting_flag_o || running_flag_o
        || prolonged_start_flag_o || restart_blocked_flag_o))
        else $error("flag active while operation off");
    start_edge_a: assert property ($rose(starting_flag_o) |-> $rose(running_flag_o))
        else $error("start flagged without current rising");
    inhibit_start_a: assert property (start_end_s |-> ##[0:1] restart_blocked_flag_o)
        else $error("restart inhibit not started at end of start");
    long_start_a: assert property ($rose(prolonged_start_flag_o) |-> $fell(starting_flag_o))
        else $error("prolonged start raised outside timer expiry");
    run_timing_a: assert property ($changed(running_flag_o) && oper_q
        |-> $past(meas_valid_i, 3) || $past(meas_valid_i, 4))
        else $error("running flag changed without a measurement");
    inhibit_hold_a: assert property ($rose(restart_blocked_flag_o)
        |-> (restart_blocked_flag_o || !oper_q) [*8])
        else $error("restart inhibit shorter than its minimum");
endmodule

bind startup_supervisor startup_supervisor_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .meas_valid_i(meas_valid_i), .starting_flag_o(starting_flag_o),
    .running_flag_o(running_flag_o), .prolonged_start_flag_o(prolonged_start_flag_o),
    .restart_blocked_flag_o(restart_blocked_flag_o));
`default_nettype wire

// ### testbench/meas_front_end.sv
// current measurement front end model: periodic three-phase magnitude results.
// assumes the bench sets the current level; the largest phase rotates each result.
`timescale 1ns/1ps
`default_nettype none
module meas_front_end (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // requested current, percent of input rated current
    input  wire logic [15:0] level_i,
    // measurement results
    output var  logic        meas_valid_o,
    output var  logic [15:0] mag_a_o,
    output var  logic [15:0] mag_b_o,
    output var  logic [15:0] mag_c_o
);
    logic [1:0] cnt_q;
    logic [1:0] ph_q;
    // a result every fourth cycle, magnitudes held between strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q        <= 2'h0;
            ph_q         <= 2'h0;
            meas_valid_o <= 1'b0;
            mag_a_o      <= 16'h0000;
            mag_b_o      <= 16'h0000;
            mag_c_o      <= 16'h0000;
        end else begin
            cnt_q        <= cnt_q + 2'h1;
            meas_valid_o <= (cnt_q == 2'h3);
            if (cnt_q == 2'h3) begin
                ph_q    <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
                mag_a_o <= (ph_q == 2'h0) ? level_i : level_i >> 2;
                mag_b_o <= (ph_q == 2'h1) ? level_i : level_i >> 2;
                mag_c_o <= (ph_q == 2'h2) ? level_i : level_i >> 2;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_startup_supervisor.sv
// self-checking bench for the startup supervisor: settings over the bus, flag sequences.
// assumes a 40 MHz clock and a second shortened to ten clocks.
`timescale 1ns/1ps
`default_nettype none
`include "startup_supervisor_defs.vh"
module tb_startup_supervisor;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [15:0] level = 16'h0000;
    logic [31:0] rdata;
    wire  logic [31:0] dat_o;
    wire  logic        ack_o;
    wire  logic        meas_valid;
    wire  logic [15:0] mag_a;
    wire  logic [15:0] mag_b;
    wire  logic [15:0] mag_c;
    wire  logic [3:0]  flags;
    int          miscompares = 0;
    int          total_checks = 0;
    int          n;
    logic [7:0]  ra [6] = '{`REG_CTRL, `REG_RATIO, `REG_START_THR, `REG_IDLE_THR,
                           `REG_START_TIME, `REG_RESTART_TIME};
    logic [31:0] re [6] = '{32'h0, 32'h64, 32'hC8, 32'h0A, 32'h05, 32'h14};
    logic [7:0]  ca [15] = '{`REG_RATIO, `REG_RATIO, `REG_RATIO, `REG_START_THR,
        `REG_START_THR, `REG_START_THR, `REG_IDLE_THR, `REG_IDLE_THR, `REG_IDLE_THR,
        `REG_START_TIME, `REG_START_TIME, `REG_START_TIME, `REG_RESTART_TIME,
        `REG_RESTART_TIME, 8'h3C};
    logic [31:0] cw [15] = '{32'h05, 32'hC8, 32'h64, 32'h7D0, 32'h14, 32'hC8, 32'h01,
        32'h3C, 32'h0A, 32'h00, 32'h65, 32'h02, 32'h1770, 32'h09, 32'h55};
    logic [31:0] ce [15] = '{32'h14, 32'h96, 32'h64, 32'h3E8, 32'h32, 32'hC8, 32'h05,
        32'h32, 32'h0A, 32'h01, 32'h64, 32'h02, 32'h1388, 32'h0A, 32'h00};

    always #12.5 clk_i = ~clk_i;

    startup_supervisor #(.TICK_CYCLES(32'h0000_000A)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .meas_valid_i(meas_valid), .mag_a_i(mag_a), .mag_b_i(mag_b), .mag_c_i(mag_c),
        .starting_flag_o(flags[0]), .running_flag_o(flags[1]),
        .prolonged_start_flag_o(flags[2]), .restart_blocked_flag_o(flags[3]));
    meas_front_end fe_u (
        .clk_i(clk_i), .rst_i(rst_i), .level_i(level), .meas_valid_o(meas_valid),
        .mag_a_o(mag_a), .mag_b_o(mag_b), .mag_c_o(mag_c));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic bus cycle, held until acknowledge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wait_flag(input int idx, input logic val, input int lim, output int k);
        k = 0;
        while (flags[idx] !== val && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= lim) check("flag wait", 32'h0, 32'h1);
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ra[i], 32'h0, rdata);
            check("reset setting", rdata, re[i]);
        end
        for (int i = 0; i < 15; i++) begin
            wb(1'b1, ca[i], cw[i], rdata);
            wb(1'b0, ca[i], 32'h0, rdata);
            check("clamped setting", rdata, ce[i]);
        end
        @(posedge clk_i) level <= 16'h01F4;
        repeat (40) @(posedge clk_i);
        check("flags while off", {28'h0, flags}, 32'h0);
        @(posedge clk_i) level <= 16'h0000;
        repeat (8) @(posedge clk_i);
        wb(1'b1, `REG_CTRL, 32'h1, rdata);
        repeat (12) @(posedge clk_i);
        // normal start below the startup level
        @(posedge clk_i) level <= 16'h0032;
        wait_flag(1, 1'b1, 20, n);
        check("starting at start", {31'h0, flags[0]}, 32'h1);
        wait_flag(0, 1'b0, 40, n);
        check("start length", 32'(n >= 9 && n <= 21), 32'h1);
        check("inhibit at expiry", {31'h0, flags[3]}, 32'h1);
        check("no long start", {31'h0, flags[2]}, 32'h0);
        // idle hysteresis: 8 holds, 6 releases
        @(posedge clk_i) level <= 16'h0008;
        repeat (30) @(posedge clk_i);
        check("running held", {31'h0, flags[1]}, 32'h1);
        @(posedge clk_i) level <= 16'h0006;
        wait_flag(1, 1'b0, 20, n);
        // locked rotor, then startup hysteresis
        @(posedge clk_i) level <= 16'h012C;
        wait_flag(0, 1'b1, 20, n);
        wait_flag(0, 1'b0, 40, n);
        check("long start", {31'h0, flags[2]}, 32'h1);
        @(posedge clk_i) level <= 16'h00C3;
        repeat (20) @(posedge clk_i);
        check("long start held", {31'h0, flags[2]}, 32'h1);
        wb(1'b0, `REG_STATUS, 32'h0, rdata);
        check("status word", rdata, 32'h0000_021E);
        wb(1'b0, `REG_IMAX, 32'h0, rdata);
        check("largest phase", rdata, 32'h0000_00C3);
        @(posedge clk_i) level <= 16'h00B9;
        wait_flag(2, 1'b0, 20, n);
        // aborted start
        @(posedge clk_i) level <= 16'h0000;
        wait_flag(3, 1'b0, 150, n);
        @(posedge clk_i) level <= 16'h0032;
        wait_flag(0, 1'b1, 20, n);
        @(posedge clk_i) level <= 16'h0000;
        wait_flag(3, 1'b1, 20, n);
        wait_flag(3, 1'b0, 130, n);
        check("inhibit length", 32'(n >= 85 && n <= 105), 32'h1);
        // switching off clears the flags, the start count is kept
        @(posedge clk_i) level <= 16'h0032;
        wait_flag(1, 1'b1, 20, n);
        wb(1'b1, `REG_CTRL, 32'h0, rdata);
        repeat (4) @(posedge clk_i);
        check("flags after off", {28'h0, flags}, 32'h0);
        wb(1'b0, `REG_START_COUNT, 32'h0, rdata);
        check("start count", rdata, 32'h0000_0004);
        end_of_test;
    end
endmodule
`default_nettype wire
